/* File: src/cell_pkg.sv */
package cell_pkg;

    localparam int NUM_DEDICATED = 6;
    localparam int SRC_W = 3;
    // Source codes 0..5 pick a dedicated input, this one picks local logic
    localparam logic [2:0] SRC_LOCAL = 3'h7;
    localparam logic STORED_RESET = 1'h0;
    localparam logic [5:0] DED_RESET = 6'h00;

    typedef enum logic [1:0] {
        OP_NORMAL,
        OP_ARITH,
        OP_UPDOWN,
        OP_CLEARABLE
    } op_mode_type;

    typedef enum logic [2:0] {
        CP_CLEAR,
        CP_PRESET,
        CP_CLEAR_PRESET,
        CP_LOAD_CLEAR,
        CP_LOAD_PRESET,
        CP_LOAD_ONLY
    } cp_mode_type;

    typedef struct packed {
        op_mode_type op_mode;
        cp_mode_type cp_mode;
        logic preset_by_invert;
        logic chip_reset_en;
        logic [15:0] normal_lut;
        logic [7:0] data_lut;
        logic [7:0] carry_lut;
        logic [2:0] clk_en_src;
        logic [2:0] ctrl_one_src;
        logic [2:0] ctrl_two_src;
    } cell_cfg_type;

    typedef struct packed {
        logic [3:0] data;
        logic clk_en;
        logic cnt_en;
        logic up_dn;
        logic load_sel;
        logic load_val;
        logic sync_clear;
        logic carry_in;
        logic cascade_in;
    } cell_in_type;

    typedef struct packed {
        logic block_control_line_one;
        logic block_control_line_two;
        logic async_load_data_input;
    } cell_ctrl_type;

endpackage

/* File: src/logic_cell.sv */
`timescale 1ns/10ps
// Overview of operation
// [RULE_01] Arithmetic: sum and carry 3-input lookups
// [RULE_02] Arithmetic keeps cascade output beside carry
// [RULE_03] Up/down counter: enables, direction, load
// [RULE_04] Counter lookups from inputs, carry, feedback
// [RULE_05] Load selector in front of register
// [RULE_06] Async load via clear/preset, no lookup
// [RULE_07] Clearable counter: sync clear replaces direction
// [RULE_08] Selector output ANDed with sync clear
// [RULE_09] Emulated bus: contention low, idle high
// [RULE_10] Clear/preset active low, unused held high
// [RULE_11] Exactly one of six clear/preset modes
// [RULE_12] Chip reset overrides all other controls
// [RULE_13] Inverted-storage preset registers reset to one
// [RULE_14] Clear mode: either line clears
// [RULE_15] Preset by loading one or inversion
// [RULE_16] Line one presets, line two clears
// [RULE_17] Line one copies load data in
// [RULE_18] Load-with-clear drives both paths, two clears
// [RULE_19] Load-with-preset stores inverted, data inverted
// [RULE_20] Load-only: line one alone loads
// [RULE_21] Six dedicated inputs as controls or data
// [RULE_22] Synchronous clock enable in every mode
// [RULE_23] Capture next state on rising edge
module logic_cell #(
    parameter int TRI_DRIVERS = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire cell_pkg::cell_cfg_type cfg_i,
    // Local interconnect and chain inputs
    input wire cell_pkg::cell_in_type cell_i,
    input wire cell_pkg::cell_ctrl_type ctrl_i,
    // Pins: chip-wide reset and dedicated inputs
    input wire logic chip_reset_i,
    input wire logic [cell_pkg::NUM_DEDICATED-1:0] dedicated_i,
    // Emulated internal bus drivers
    input wire logic [TRI_DRIVERS-1:0] tri_data_i,
    input wire logic [TRI_DRIVERS-1:0] tri_oe_i,
    // Outputs
    output logic q_o,
    output logic lut_o,
    output logic carry_o,
    output logic cascade_o,
    output logic tri_bus_o,
    output logic [cell_pkg::NUM_DEDICATED-1:0] dedicated_data_o
);

    typedef struct packed {
        logic [cell_pkg::NUM_DEDICATED-1:0] ded_meta;
        logic [cell_pkg::NUM_DEDICATED-1:0] ded_sync;
        logic rst_meta;
        logic rst_sync;
        logic stored;
        logic q;
        logic tri_bus;
    } state_type;

    state_type state_ff;
    state_type nxt_state;

    if (TRI_DRIVERS < 1)
    begin : g_bad_drivers
        $error("TRI_DRIVERS must be at least 1");
    end

    function automatic logic lut3(input logic [7:0] mask, input logic [2:0] idx);
        lut3 = mask[idx];
    endfunction

    function automatic logic pick(input logic [2:0] src, input logic local_val,
                                  input logic [cell_pkg::NUM_DEDICATED-1:0] ded);
        if (src < 3'(cell_pkg::NUM_DEDICATED))
        begin
            pick = ded[src];
        end
        else
        begin
            pick = local_val;
        end
    endfunction

    logic clk_en;
    logic line_one;
    logic line_two;
    logic [2:0] cnt_idx;
    logic cnt_bit;
    logic sel_bit;
    logic d_bit;
    logic inv;
    logic load_data;
    logic clr_n;
    logic pre_n;
    logic chip_rst;
    logic [$clog2(TRI_DRIVERS+1)-1:0] oe_count;

    always_comb
    begin
        nxt_state = state_ff;
        // Pins go through two flops before use
        nxt_state.ded_meta = dedicated_i;
        nxt_state.ded_sync = state_ff.ded_meta;
        nxt_state.rst_meta = chip_reset_i;
        nxt_state.rst_sync = state_ff.rst_meta;

        // [RULE_21] dedicated control sources
        clk_en = pick(cfg_i.clk_en_src, cell_i.clk_en, state_ff.ded_sync);
        line_one = pick(cfg_i.ctrl_one_src, ctrl_i.block_control_line_one,
                        state_ff.ded_sync);
        line_two = pick(cfg_i.ctrl_two_src, ctrl_i.block_control_line_two,
                        state_ff.ded_sync);

        lut_o = cfg_i.normal_lut[cell_i.data];
        carry_o = 1'h0;
        cascade_o = lut_o & cell_i.cascade_in;
        d_bit = lut_o;
        cnt_bit = 1'h0;
        sel_bit = 1'h0;
        cnt_idx = {cell_i.up_dn, state_ff.q, cell_i.carry_in & cell_i.cnt_en};
        unique case (cfg_i.op_mode)
            cell_pkg::OP_NORMAL:
            begin
                d_bit = lut_o;
            end
            cell_pkg::OP_ARITH:
            begin
                // [RULE_01] sum and carry lookups
                lut_o = lut3(cfg_i.data_lut, {cell_i.carry_in, cell_i.data[1:0]});
                carry_o = lut3(cfg_i.carry_lut, {cell_i.carry_in, cell_i.data[1:0]});
                // [RULE_02] cascade alongside carry
                cascade_o = lut_o & cell_i.cascade_in;
                d_bit = lut_o;
            end
            cell_pkg::OP_UPDOWN:
            begin
                // [RULE_03] direction and count enable
                // [RULE_04] count and carry lookups
                cnt_bit = lut3(cfg_i.data_lut, cnt_idx);
                carry_o = lut3(cfg_i.carry_lut, cnt_idx);
                lut_o = cnt_bit;
                cascade_o = cnt_bit & cell_i.cascade_in;
                // [RULE_05] synchronous load selector
                d_bit = cell_i.load_sel ? cell_i.load_val : cnt_bit;
            end
            cell_pkg::OP_CLEARABLE:
            begin
                // [RULE_07] clear replaces direction, up_dn unused
                cnt_idx = {cell_i.cnt_en, state_ff.q, cell_i.carry_in};
                cnt_bit = lut3(cfg_i.data_lut, cnt_idx);
                carry_o = lut3(cfg_i.carry_lut, cnt_idx);
                lut_o = cnt_bit;
                cascade_o = 1'h0;
                sel_bit = cell_i.load_sel ? cell_i.load_val : cnt_bit;
                // [RULE_08] clear gates selector output
                d_bit = sel_bit & ~cell_i.sync_clear;
            end
        endcase

        // [RULE_19] inverted storage when preset uses clear
        inv = (cfg_i.cp_mode == cell_pkg::CP_LOAD_PRESET) ||
              (cfg_i.cp_mode == cell_pkg::CP_PRESET && cfg_i.preset_by_invert);
        load_data = inv ? ~ctrl_i.async_load_data_input
                        : ctrl_i.async_load_data_input;

        // [RULE_10] unused clear/preset held high
        clr_n = 1'h1;
        pre_n = 1'h1;
        // [RULE_11] one of six modes
        // [RULE_06] async load without lookups
        unique case (cfg_i.cp_mode)
            cell_pkg::CP_CLEAR:
            begin
                // [RULE_14] either line clears
                clr_n = ~(line_one | line_two);
            end
            cell_pkg::CP_PRESET:
            begin
                // [RULE_15] load one or inverted clear
                if (cfg_i.preset_by_invert)
                begin
                    clr_n = ~line_one;
                end
                else
                begin
                    pre_n = ~line_one;
                end
            end
            cell_pkg::CP_CLEAR_PRESET:
            begin
                // [RULE_16] one presets, two clears
                pre_n = ~line_one;
                clr_n = ~line_two;
            end
            cell_pkg::CP_LOAD_CLEAR, cell_pkg::CP_LOAD_PRESET:
            begin
                // [RULE_17] load data copied in
                // [RULE_18] line two only on clear path
                pre_n = ~(line_one & load_data);
                clr_n = ~((line_one & ~load_data) | line_two);
            end
            cell_pkg::CP_LOAD_ONLY:
            begin
                // [RULE_20] line one alone loads
                pre_n = ~(line_one & load_data);
                clr_n = ~(line_one & ~load_data);
            end
            default:
            begin
                clr_n = 1'h1;
                pre_n = 1'h1;
            end
        endcase

        chip_rst = cfg_i.chip_reset_en & state_ff.rst_sync;
        // [RULE_12] chip reset wins over everything
        if (chip_rst)
        begin
            // [RULE_13] inverted storage reads back as one
            nxt_state.stored = 1'h0;
        end
        else if (!clr_n)
        begin
            // Clear wins if both paths are low
            nxt_state.stored = 1'h0;
        end
        else if (!pre_n)
        begin
            nxt_state.stored = 1'h1;
        end
        // [RULE_22] synchronous clock enable
        else if (clk_en)
        begin
            // [RULE_23] capture selected next state
            nxt_state.stored = inv ? ~d_bit : d_bit;
        end
        nxt_state.q = nxt_state.stored ^ inv;

        // [RULE_09] contention low, idle high
        oe_count = '0;
        nxt_state.tri_bus = 1'h1;
        for (int i = 0; i < TRI_DRIVERS; i++)
        begin
            if (tri_oe_i[i])
            begin
                oe_count = oe_count + 1'b1;
                nxt_state.tri_bus = tri_data_i[i];
            end
        end
        if (oe_count > 1)
        begin
            nxt_state.tri_bus = 1'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= '{ded_meta: cell_pkg::DED_RESET, ded_sync: cell_pkg::DED_RESET,
                          rst_meta: 1'h0, rst_sync: 1'h0,
                          stored: cell_pkg::STORED_RESET, q: 1'h0, tri_bus: 1'h1};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign q_o = state_ff.q;
    assign tri_bus_o = state_ff.tri_bus;
    assign dedicated_data_o = state_ff.ded_sync;

endmodule

/* File: tb/logic_cell_props.sv */
`timescale 1ns/10ps
module logic_cell_props #(
    parameter int TRI_DRIVERS = 4
) (
    // Clock, reset and inputs
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire cell_pkg::cell_cfg_type cfg_i,
    input wire cell_pkg::cell_in_type cell_i,
    input wire cell_pkg::cell_ctrl_type ctrl_i,
    input wire logic [TRI_DRIVERS-1:0] tri_data_i,
    input wire logic [TRI_DRIVERS-1:0] tri_oe_i,
    // Outputs
    input wire logic q_o,
    input wire logic lut_o,
    input wire logic carry_o,
    input wire logic cascade_o,
    input wire logic tri_bus_o
);
    cell_pkg::cp_mode_type cp;
    assign cp = cfg_i.cp_mode;
    wire one = ctrl_i.block_control_line_one;
    wire two = ctrl_i.block_control_line_two;
    // Dedicated sources and chip reset add latency, so only local controls
    wire ok = !cfg_i.chip_reset_en && cfg_i.ctrl_one_src == 3'h7
        && cfg_i.ctrl_two_src == 3'h7 && cfg_i.clk_en_src == 3'h7;
    wire [2:0] ai = {cell_i.carry_in, cell_i.data[1:0]};
    wire arith = cfg_i.op_mode == cell_pkg::OP_ARITH;
    wire bus = tri_oe_i == '0 ? 1'h1 : $onehot(tri_oe_i) && |(tri_oe_i & tri_data_i);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_arith;
        arith |-> lut_o == cfg_i.data_lut[ai] && carry_o == cfg_i.carry_lut[ai];
    endproperty
    a_arith: assert property (p_arith) else $error("arith lookup");
    property p_cascade;
        arith |-> cascade_o == (lut_o & cell_i.cascade_in);
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade out");
    property p_bus;
        1'h1 |=> tri_bus_o == $past(bus);
    endproperty
    a_bus: assert property (p_bus) else $error("bus resolve");
    property p_clear;
        ok && (cp == cell_pkg::CP_CLEAR && (one || two) || cp == cell_pkg::CP_LOAD_CLEAR && two)
            |=> !q_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear");
    property p_preset;
        ok && one && !two && (cp == cell_pkg::CP_CLEAR_PRESET || cp == cell_pkg::CP_PRESET)
            |=> q_o;
    endproperty
    a_preset: assert property (p_preset) else $error("preset");
    property p_load;
        ok && one && !two && cp >= cell_pkg::CP_LOAD_CLEAR
            |=> q_o == $past(ctrl_i.async_load_data_input);
    endproperty
    a_load: assert property (p_load) else $error("load");
    property p_ldpre;
        ok && two && !one && cp == cell_pkg::CP_LOAD_PRESET |=> q_o;
    endproperty
    a_ldpre: assert property (p_ldpre) else $error("load preset");
    property p_hold;
        ok && !cell_i.clk_en && !one && !two |=> $stable(q_o);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule
bind logic_cell logic_cell_props #(.TRI_DRIVERS(TRI_DRIVERS)) u_logic_cell_props (.clk_i,
    .rst_n_i, .cfg_i, .cell_i, .ctrl_i, .tri_data_i, .tri_oe_i, .q_o, .lut_o, .carry_o,
    .cascade_o, .tri_bus_o);

/* File: tb/bus_user.sv */
`timescale 1ns/10ps
module bus_user (
    // Clock
    input wire logic clk_i,
    // Scenario and bus drivers
    input wire logic [1:0] pick_i,
    output logic [3:0] tri_data_o,
    output logic [3:0] tri_oe_o
);
    logic [1:0] pick_ff = 2'h0;
    logic noise_ff = 1'h0;
    always_ff @(posedge clk_i)
    begin
        pick_ff <= pick_i;
        noise_ff <= ~noise_ff;
    end
    // Disabled lanes toggle so stale data cannot leak through
    always_comb
    begin
        tri_oe_o = pick_ff == 2'h1 ? 4'h1 : pick_ff == 2'h2 ? 4'h4 : pick_ff == 2'h3 ? 4'h3 : 4'h0;
        tri_data_o = tri_oe_o & {4{pick_ff[1]}} | ~tri_oe_o & {4{noise_ff}};
    end
endmodule

/* File: tb/logic_cell_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module logic_cell_bench;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    cell_pkg::cell_cfg_type cfg_i;
    cell_pkg::cell_in_type cell_i;
    cell_pkg::cell_ctrl_type ctrl_i;
    logic chip_reset_i = 1'h0;
    logic [5:0] dedicated_i = 6'h00;
    logic [1:0] pick = 2'h0;
    logic [3:0] tri_data_i;
    logic [3:0] tri_oe_i;
    logic q_o, lut_o, carry_o, cascade_o, tri_bus_o;
    logic [5:0] dedicated_data_o;
    int bad_count = 0;
    int n_compared = 0;
    localparam logic [7:0] CV [8] = '{8'h90, 8'h98, 8'hC2, 8'hC2, 8'h82, 8'h98, 8'h9C, 8'h98};
    always #12.5 clk_i = ~clk_i;
    logic_cell u_logic_cell (.clk_i, .rst_n_i, .cfg_i, .cell_i, .ctrl_i, .chip_reset_i,
        .dedicated_i, .tri_data_i, .tri_oe_i, .q_o, .lut_o, .carry_o, .cascade_o,
        .tri_bus_o, .dedicated_data_o);
    bus_user u_bus_user (.clk_i, .pick_i(pick), .tri_data_o(tri_data_i), .tri_oe_o(tri_oe_i));
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Preload p by capture, then one control cycle with clock enable off
    task automatic act(input logic p, o, t, ld, e);
        cell_i.clk_en = 1'h1;
        cell_i.data = {3'h0, p};
        tick(1);
        cell_i.clk_en = 1'h0;
        ctrl_i = '{o, t, ld};
        tick(1);
        ctrl_i = '0;
        `CHK("q", e, q_o)
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
    initial
    begin
        cfg_i = '{cell_pkg::OP_NORMAL, cell_pkg::CP_CLEAR, 1'h0, 1'h0, 16'hAAAA,
            8'h96, 8'hE8, 3'h7, 3'h7, 3'h7};
        cell_i = '0;
        ctrl_i = '0;
        tick(8);
        `CHK("reset bus", 1'h1, tri_bus_o)
        rst_n_i = 1'h1;
        dedicated_i = 6'h2D;
        tick(3);
        `CHK("dedicated", 6'h2D, dedicated_data_o)
        for (int m = 0; m < 6; m++)
        begin
            cfg_i.cp_mode = cell_pkg::cp_mode_type'(m);
            act(~m[0], 1'h1, 1'h0, m[0], 1'(6'h2E >> m));
            if (m != 1)
                act(1'(6'h30 >> m) ^ (m != 5), 1'h0, 1'h1, 1'h0, 1'(6'h30 >> m));
        end
        cell_i.data = 4'h0;
        tick(2);
        `CHK("hold", 1'h1, q_o)
        cfg_i.preset_by_invert = 1'h1;
        cfg_i.cp_mode = cell_pkg::CP_PRESET;
        act(1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
        cfg_i.cp_mode = cell_pkg::CP_CLEAR_PRESET;
        act(1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
        cfg_i.op_mode = cell_pkg::OP_ARITH;
        for (int i = 0; i < 16; i++)
        begin
            {cell_i.cascade_in, cell_i.carry_in, cell_i.data[1:0]} = i[3:0];
            #1;
            `CHK("sum", ^i[2:0], lut_o)
            `CHK("carry", i[2] & i[1] | i[2] & i[0] | i[1] & i[0], carry_o)
            `CHK("cascade", i[3] & ^i[2:0], cascade_o)
        end
        cfg_i.data_lut = 8'h66;
        for (int k = 0; k < 8; k++)
        begin
            cfg_i.op_mode = k < 5 ? cell_pkg::OP_UPDOWN : cell_pkg::OP_CLEARABLE;
            cell_i = {4'h0, CV[k]};
            tick(1);
            `CHK("count", 1'(8'hBA >> k), q_o)
        end
        cell_i = '0;
        cfg_i.chip_reset_en = 1'h1;
        for (int m = 2; m < 5; m += 2)
        begin
            cfg_i.cp_mode = cell_pkg::cp_mode_type'(m);
            ctrl_i = '{1'h1, 1'h0, 1'h0};
            chip_reset_i = 1'h1;
            tick(4);
            `CHK("chip reset", m == 4, q_o)
            chip_reset_i = 1'h0;
            ctrl_i = '0;
            tick(3);
        end
        for (int k = 0; k < 4; k++)
        begin
            pick = k[1:0];
            tick(2);
            `CHK("bus", 1'(4'h5 >> k), tri_bus_o)
        end
        // Line one taken from dedicated input 0, which stands high
        cfg_i.cp_mode = cell_pkg::CP_CLEAR_PRESET;
        cfg_i.ctrl_one_src = 3'h0;
        tick(2);
        `CHK("dedicated preset", 1'h1, q_o)
        test_done();
    end
endmodule
